// >>> rtl/modem_byte_buffer_flags.sv
// Modem data byte holding registers, event flags and interrupt mask
`timescale 1ns/10ps
`include "modem_consts.svh"

module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = `FIFO_DEPTH_DEF
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Fill side
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    // Drain side
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push, pop;
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("byte_fifo depth must be a power of two of at least 2");
    end
    assign in_ready_out = (count_ff != DEPTH[AW:0]);
    assign out_valid_out = (count_ff != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_ff[rd_ptr_ff];
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// Function
// - Reading the flag register clears the pending flags.
// - Mask bits 7, 4 and 3 gate parity, overflow and byte-ready events.
// - Writing 1 to the receive enable bit starts byte reception.
// - A byte arriving before the last was read sets overflow and wins.
// - Byte-ready stays set beside overflow if flags were not read.
// - A flag read clears ready and overflow until the byte is read.
// - An empty transmit register at byte end sets underflow and marks.
// - Byte-wanted stays set beside underflow if flags were not read.
// - A flag read clears wanted and underflow until a new load.
// - A stop-bit change applies at once, to the byte now being sent.
// - Mask bits 2 and 1 gate the underflow and byte-wanted events.
// - Transmit enable 1 sends the loaded byte, 0 ends transmission.
module modem_byte_buffer_flags #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Host register port
    input wire logic [7:0] host_addr_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire modem_pkg::byte_t host_wdata_in,
    output modem_pkg::byte_t host_rdata_out,
    output logic host_rvalid_out,
    // Received characters from the deframer
    input wire modem_pkg::byte_t rx_char_in,
    input wire logic rx_parity_err_in,
    input wire logic rx_char_valid_in,
    output logic rx_char_ready_out,
    // Transmit serialiser
    output modem_pkg::byte_t tx_shift_byte_out,
    output logic tx_load_out,
    output logic tx_mark_out,
    output logic tx_enable_out,
    output logic tx_stop_bits_out,
    input wire logic tx_byte_done_in,
    // Receive enable to the demodulator
    output logic rx_enable_out,
    // Open-drain interrupt request
    output logic interrupt_request_n_out,
    output logic interrupt_request_oe_out
);
    import modem_pkg::*;

    byte_t rx_ctrl_ff, tx_ctrl_ff, mask_ff, flags_ff, nxt_flags;
    byte_t rx_byte_ff, tx_hold_ff, rdata_ff, shift_ff;
    logic rvalid_ff, rx_unread_ff, rx_arm_ff, tx_full_ff, tx_arm_ff, load_ff;
    tx_state_e tx_state_ff, nxt_tx_state;
    logic [8:0] fifo_data;
    logic fifo_valid, rx_take, tx_take, tx_under;
    logic flags_rd, rx_byte_rd, tx_wr;
    if (FIFO_DEPTH < 2) begin : g_bad_param
        $error("FIFO_DEPTH must be at least 2");
    end
    assign flags_rd = host_rd_in && host_addr_in == `ADDR_FLAGS;
    assign rx_byte_rd = host_rd_in && host_addr_in == `ADDR_RX_BYTE;
    assign tx_wr = host_wr_in && host_addr_in == `ADDR_TX_BYTE;
    // Characters wait here while reception is off; the deframer stalls
    byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_data_in({rx_parity_err_in, rx_char_in}),
        .in_valid_in(rx_char_valid_in),
        .in_ready_out(rx_char_ready_out),
        .out_data_out(fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in(rx_enable_out)
    );

    assign rx_enable_out = rx_ctrl_ff[`BIT_ENABLE];
    assign rx_take = fifo_valid && rx_enable_out;
    assign tx_enable_out = tx_ctrl_ff[`BIT_ENABLE];
    // Taken straight from the register, so the current byte sees it
    assign tx_stop_bits_out = tx_ctrl_ff[`BIT_STOP_BITS];
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_ctrl_ff <= `RESET_BYTE;
            tx_ctrl_ff <= `RESET_BYTE;
            mask_ff <= `RESET_BYTE;
        end else if (host_wr_in) begin
            case (host_addr_in)
                `ADDR_RX_CTRL: rx_ctrl_ff <= host_wdata_in;
                `ADDR_TX_CTRL: tx_ctrl_ff <= host_wdata_in;
                `ADDR_IRQ_MASK: mask_ff <= host_wdata_in;
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_ff <= `RESET_BYTE;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= host_rd_in;
            if (host_rd_in) begin
                case (host_addr_in)
                    `ADDR_RX_CTRL: rdata_ff <= rx_ctrl_ff;
                    `ADDR_TX_CTRL: rdata_ff <= tx_ctrl_ff;
                    `ADDR_RX_BYTE: rdata_ff <= rx_byte_ff;
                    `ADDR_IRQ_MASK: rdata_ff <= mask_ff;
                    `ADDR_FLAGS: rdata_ff <= flags_ff;
                    default: rdata_ff <= `RESET_BYTE;
                endcase
            end
        end
    end
    assign host_rdata_out = rdata_ff;
    assign host_rvalid_out = rvalid_ff;

    // Receive holding register: newest byte always wins
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_byte_ff <= `RESET_BYTE;
            rx_unread_ff <= 1'b0;
        end else begin
            if (rx_take) begin
                rx_byte_ff <= fifo_data[7:0];
            end
            rx_unread_ff <= rx_take || (rx_unread_ff && !rx_byte_rd);
        end
    end
    // Rx ready and overflow rest after a flag read until the byte is read again
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_arm_ff <= 1'b1;
        end else if (rx_byte_rd) begin
            rx_arm_ff <= 1'b1;
        end else if (flags_rd && (flags_ff[`BIT_RX_READY] ||
                                  flags_ff[`BIT_RX_OVERFLOW])) begin
            rx_arm_ff <= 1'b0;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_arm_ff <= 1'b1;
        end else if (tx_wr) begin
            tx_arm_ff <= 1'b1;
        end else if (flags_rd && (flags_ff[`BIT_TX_READY] ||
                                  flags_ff[`BIT_TX_UNDERFLOW])) begin
            tx_arm_ff <= 1'b0;
        end
    end
    // Transmit sequencer
    always_comb begin
        nxt_tx_state = tx_state_ff;
        tx_take = 1'b0;
        tx_under = 1'b0;
        case (tx_state_ff)
            TX_IDLE: begin
                if (tx_enable_out && tx_full_ff) begin
                    nxt_tx_state = TX_SEND;
                    tx_take = 1'b1;
                end
            end
            TX_SEND: begin
                if (tx_byte_done_in) begin
                    if (tx_full_ff) begin
                        tx_take = 1'b1;
                    end else begin
                        nxt_tx_state = TX_MARK;
                        tx_under = 1'b1;
                    end
                end
            end
            TX_MARK: begin
                if (tx_full_ff) begin
                    nxt_tx_state = TX_SEND;
                    tx_take = 1'b1;
                end
            end
            default: nxt_tx_state = TX_IDLE;
        endcase
        if (!tx_enable_out) begin
            nxt_tx_state = TX_IDLE;
            tx_take = 1'b0;
            tx_under = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_state_ff <= TX_IDLE;
            load_ff <= 1'b0;
            shift_ff <= `RESET_BYTE;
        end else begin
            tx_state_ff <= nxt_tx_state;
            load_ff <= tx_take;
            if (tx_take) begin
                shift_ff <= tx_hold_ff;
            end
        end
    end
    // A host write in the cycle of a take refills the register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_hold_ff <= `RESET_BYTE;
            tx_full_ff <= 1'b0;
        end else begin
            if (tx_wr) begin
                tx_hold_ff <= host_wdata_in;
            end
            tx_full_ff <= tx_wr || (tx_full_ff && !tx_take);
        end
    end
    assign tx_shift_byte_out = shift_ff;
    assign tx_load_out = load_ff;
    assign tx_mark_out = (tx_state_ff == TX_MARK);
    // Event flags: a new event in the cycle of a flag read survives it
    always_comb begin
        nxt_flags = flags_rd ? `RESET_BYTE : flags_ff;
        if (rx_take && rx_arm_ff) begin
            nxt_flags[`BIT_RX_READY] = 1'b1;
            if (rx_unread_ff) begin
                nxt_flags[`BIT_RX_OVERFLOW] = 1'b1;
            end
        end
        if (rx_take && fifo_data[8]) begin
            nxt_flags[`BIT_RX_PARITY] = 1'b1;
        end
        if (tx_take && tx_arm_ff) begin
            nxt_flags[`BIT_TX_READY] = 1'b1;
        end
        if (tx_under && tx_arm_ff) begin
            nxt_flags[`BIT_TX_UNDERFLOW] = 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flags_ff <= `RESET_BYTE;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // Pin only ever pulls low; the wire idles high through the pull-up
    assign interrupt_request_n_out = 1'b0;
    assign interrupt_request_oe_out = |(flags_ff & mask_ff);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_flag_read;
        flags_rd && !rx_take && !tx_take && !tx_under;
    endsequence
    chk_flag_read_clear: assert property (
        s_flag_read |=> flags_ff == `RESET_BYTE)
        else $error("flag read did not clear flags");
    chk_overflow_set: assert property (
        rx_take && rx_unread_ff && rx_arm_ff |=>
        flags_ff[`BIT_RX_OVERFLOW] && flags_ff[`BIT_RX_READY])
        else $error("overflow not flagged");
    chk_newest_byte: assert property (
        rx_take |=> rx_byte_ff == $past(fifo_data[7:0]))
        else $error("received byte not overwritten");
    chk_rx_quiet: assert property (
        !rx_arm_ff && !rx_byte_rd |=> !$rose(flags_ff[`BIT_RX_READY]))
        else $error("ready flag set before byte read");
    chk_tx_quiet: assert property (
        !tx_arm_ff && !tx_wr |=> !$rose(flags_ff[`BIT_TX_UNDERFLOW]))
        else $error("underflow flag set before load");
    chk_underflow_mark: assert property (
        tx_state_ff == TX_SEND && tx_byte_done_in && !tx_full_ff &&
        tx_enable_out |=> tx_mark_out)
        else $error("underflow did not send mark");
    chk_tx_stop: assert property (
        !tx_enable_out |=> tx_state_ff == TX_IDLE && !tx_load_out)
        else $error("transmit ran while disabled");
    chk_rx_disabled: assert property (
        !rx_enable_out |=> $stable(rx_byte_ff))
        else $error("byte taken while reception off");
    chk_irq_pin: assert property (
        s_flag_read |=> !interrupt_request_oe_out)
        else $error("interrupt pin held after flag read");
    chk_parity_flag: assert property (
        rx_take && fifo_data[8] |=> flags_ff[`BIT_RX_PARITY])
        else $error("parity flag missing");
endmodule

// >>> rtl/modem_consts.svh
// Register offsets, field positions and reset values of the byte buffer
`ifndef MODEM_CONSTS_SVH
`define MODEM_CONSTS_SVH
`define ADDR_TX_BYTE 8'hE3
`define ADDR_TX_CTRL 8'hE7
`define ADDR_RX_CTRL 8'hE8
`define ADDR_RX_BYTE 8'hEA
`define ADDR_IRQ_MASK 8'hEE
`define ADDR_FLAGS 8'hEF
`define BIT_RX_PARITY 7
`define BIT_RX_OVERFLOW 4
`define BIT_RX_READY 3
`define BIT_TX_UNDERFLOW 2
`define BIT_TX_READY 1
`define BIT_ENABLE 7
`define BIT_STOP_BITS 0
`define RESET_BYTE 8'h00
`define FIFO_DEPTH_DEF 32
`endif

// >>> rtl/modem_pkg.sv
// Types shared by the modem byte buffer block
package modem_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01,
        TX_MARK = 2'b10
    } tx_state_e;
endpackage

// >>> verification/host_model.sv
// Host controller model driving the modem register port one byte at a time
`timescale 1ns/10ps

module host_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Command side
    input wire logic go_in,
    input wire logic we_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic busy_out,
    output logic [7:0] rdata_out,
    // Register port side
    output logic [7:0] host_addr_out,
    output logic host_wr_out,
    output logic host_rd_out,
    output logic [7:0] host_wdata_out,
    input wire logic [7:0] host_rdata_in,
    input wire logic host_rvalid_in
);
    // Idle address and data toggle so a stale value is never mistaken
    always_ff @(posedge clk_in) begin
        host_wr_out <= 1'b0;
        host_rd_out <= 1'b0;
        if (rst_in) begin
            busy_out <= 1'b0;
            host_addr_out <= 8'h00;
            host_wdata_out <= 8'h00;
        end else if (go_in && !busy_out) begin
            host_addr_out <= addr_in;
            host_wdata_out <= wdata_in;
            host_wr_out <= we_in;
            host_rd_out <= !we_in;
            busy_out <= !we_in;
        end else begin
            host_addr_out <= ~host_addr_out;
            host_wdata_out <= ~host_wdata_out;
        end
        if (!rst_in && host_rvalid_in) begin
            rdata_out <= host_rdata_in;
            busy_out <= 1'b0;
        end
    end
endmodule

// >>> verification/test_modem_byte_buffer_flags.sv
// Self-checking bench for the modem byte buffer and event flags
`timescale 1ns/10ps

module test_modem_byte_buffer_flags;
    import modem_pkg::*;
    localparam int FD = 4;
    logic clk_in = 1'b0, rst_in = 1'b1;
    logic go = 1'b0, we = 1'b0, busy;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [7:0] h_addr, h_wdata;
    logic h_wr, h_rd, rvalid;
    byte_t rdata_bus, rx_char = 8'h00, tx_byte;
    logic rx_perr = 1'b0, rx_valid = 1'b0, rx_ready, tx_done = 1'b0;
    logic tx_load, tx_mark, tx_en, tx_stop, rx_en, irq_n, irq_oe;
    int mismatches = 0, n_tests = 0, cycles = 0, i;
    logic [7:0] reg_addrs [5] = '{8'hE8, 8'hEA, 8'hEE, 8'hEF, 8'h00};

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
$display("CHECK FAILED t=%0t got %h expected %h", $time, g, e); end end

    always #5 clk_in = ~clk_in;

    host_model host_u (.clk_in(clk_in), .rst_in(rst_in), .go_in(go),
        .we_in(we), .addr_in(addr), .wdata_in(wdata), .busy_out(busy),
        .rdata_out(rdata), .host_addr_out(h_addr), .host_wr_out(h_wr),
        .host_rd_out(h_rd), .host_wdata_out(h_wdata),
        .host_rdata_in(rdata_bus), .host_rvalid_in(rvalid));

    modem_byte_buffer_flags #(.FIFO_DEPTH(FD)) dut_u (.clk_in(clk_in),
        .rst_in(rst_in), .host_addr_in(h_addr), .host_wr_in(h_wr),
        .host_rd_in(h_rd), .host_wdata_in(h_wdata),
        .host_rdata_out(rdata_bus), .host_rvalid_out(rvalid),
        .rx_char_in(rx_char), .rx_parity_err_in(rx_perr),
        .rx_char_valid_in(rx_valid), .rx_char_ready_out(rx_ready),
        .tx_shift_byte_out(tx_byte), .tx_load_out(tx_load),
        .tx_mark_out(tx_mark), .tx_enable_out(tx_en),
        .tx_stop_bits_out(tx_stop), .tx_byte_done_in(tx_done),
        .rx_enable_out(rx_en), .interrupt_request_n_out(irq_n),
        .interrupt_request_oe_out(irq_oe));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        go = 1'b1;
        we = 1'b1;
        addr = a;
        wdata = d;
        tick(1);
        go = 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        int k;
        go = 1'b1;
        we = 1'b0;
        addr = a;
        tick(1);
        go = 1'b0;
        for (k = 0; k < 10 && busy !== 1'b0; k++) begin
            tick(1);
        end
        `CHK(rdata, e)
    endtask

    // Holds valid until the buffer accepts, bounded so a stuck ready shows
    task automatic push(input logic [7:0] d, input logic pe);
        int k;
        rx_char = d;
        rx_perr = pe;
        rx_valid = 1'b1;
        for (k = 0; k < 10 && rx_ready !== 1'b1; k++) begin
            tick(1);
        end
        tick(1);
        rx_valid = 1'b0;
        rx_char = ~d;
        tick(3);
    endtask

    task automatic wait_load();
        int k;
        for (k = 0; k < 10 && tx_load !== 1'b1; k++) begin
            tick(1);
        end
        `CHK(tx_load, 1'b1)
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end

    initial begin
        tick(5);
        rst_in = 1'b0;
        foreach (reg_addrs[i]) begin
            rd(reg_addrs[i], 8'h00);
        end
        `CHK(irq_oe, 1'b0)
        wr(8'hEF, 8'hFF);
        rd(8'hEF, 8'h00);
        // Receive start-up in the order the host must keep
        rd(8'hEA, 8'h00);
        rd(8'hEF, 8'h00);
        wr(8'hEE, 8'h98);
        wr(8'hE8, 8'h80);
        `CHK(rx_en, 1'b1)
        push(8'hA5, 1'b0);
        `CHK(irq_oe, 1'b1)
        `CHK(irq_n, 1'b0)
        rd(8'hEF, 8'h08);
        `CHK(irq_oe, 1'b0)
        rd(8'hEA, 8'hA5);
        // Second byte lands before the first is read
        push(8'h11, 1'b0);
        push(8'h22, 1'b0);
        rd(8'hEF, 8'h18);
        push(8'h33, 1'b0);
        rd(8'hEF, 8'h00);
        rd(8'hEA, 8'h33);
        push(8'h44, 1'b1);
        `CHK(irq_oe, 1'b1)
        rd(8'hEF, 8'h88);
        rd(8'hEA, 8'h44);
        // Transmit with underflow and recovery
        wr(8'hEE, 8'h06);
        wr(8'hE3, 8'h5A);
        wr(8'hE7, 8'h81);
        wait_load();
        `CHK(tx_byte, 8'h5A)
        `CHK(tx_stop, 1'b1)
        wr(8'hE7, 8'h80);
        `CHK(tx_stop, 1'b0)
        rd(8'hE7, 8'h80);
        tx_done = 1'b1;
        tick(1);
        tx_done = 1'b0;
        tick(2);
        `CHK(tx_mark, 1'b1)
        `CHK(irq_oe, 1'b1)
        wr(8'hEE, 8'h00);
        `CHK(irq_oe, 1'b0)
        rd(8'hEF, 8'h06);
        rd(8'hEF, 8'h00);
        wr(8'hE3, 8'hC3);
        wait_load();
        `CHK(tx_byte, 8'hC3)
        tick(1);
        `CHK(tx_mark, 1'b0)
        rd(8'hEF, 8'h02);
        wr(8'hE7, 8'h00);
        `CHK(tx_en, 1'b0)
        // Fill the receive buffer with reception off, then drain it
        wr(8'hE8, 8'h00);
        for (i = 0; i < FD; i++) begin
            push(8'(i + 1), 1'b0);
        end
        `CHK(rx_ready, 1'b0)
        rd(8'hEA, 8'h44);
        wr(8'hE8, 8'h80);
        tick(3 * FD);
        `CHK(rx_ready, 1'b1)
        rd(8'hEA, 8'(FD));
        summarize();
    end
endmodule
